// >>> design/serial_port.sv
// Purpose: serial port engine, shift mode and ten-bit frame mode
// Assumes: pins synchronous to clock; timer1Ovf a one-cycle pulse
// Notes:   register 0 is the buffer, register 1 the control flags
module serial_port (
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire serial_pkg::busReq_t busReq,
    output logic               [7:0] rdData,
    input  wire logic                timer1Ovf,
    input  wire logic                port1Line1In,
    output logic                     port1Line1Out,
    output logic                     port1Line1Oe,
    output logic                     port1Line0Out
);

    // ************************************************************
    // machine cycle timing
    // ************************************************************
    logic [3:0] phase;

    machine_phase u_phase (
        .clock   (clock),
        .reset_n (reset_n),
        .phase   (phase)
    );

    function automatic logic [3:0] nextPhase(input logic [3:0] p);
        return (p == serial_pkg::PH_LAST) ? serial_pkg::PH_S1P1 : p + 4'h1;
    endfunction

    // shift clock low in S3..S5, high in S6, S1, S2
    function automatic logic clockLevel(input logic [3:0] p);
        return !(p >= serial_pkg::PH_S3P1 && p < serial_pkg::PH_S6P1);
    endfunction

    wire logic isS1P1 = (phase == serial_pkg::PH_S1P1);
    wire logic isS5P2 = (phase == serial_pkg::PH_S5P2);
    wire logic isS6P2 = (phase == serial_pkg::PH_S6P2);

    // ************************************************************
    // registers and bus decode
    // ************************************************************
    serial_pkg::ctrl_t    ctrl_r;
    serial_pkg::txState_t txState_r;
    serial_pkg::rxState_t rxState_r;
    logic           [7:0] rxBuf_r;
    logic           [8:0] txShift_r;
    logic           [8:0] rxShift_r;
    logic                 txPend_r;
    logic                 txLast_r;
    logic                 txData_r;
    logic                 rxLast_r;
    logic                 rxFirst_r;
    logic                 rxArm_r;
    logic                 rxSample_r;
    logic                 rxPrev_r;
    logic                 halfTog_r;
    logic           [3:0] div16_r;
    logic                 rollPend_r;
    logic           [7:0] rdData_r;
    logic                 line0_r;
    logic                 line1_r;
    logic                 line1Oe_r;

    wire logic bufWr  = busReq.wr && busReq.addr == serial_pkg::ADDR_BUFFER;
    wire logic ctlWr  = busReq.wr && busReq.addr == serial_pkg::ADDR_CONTROL;
    wire logic mode0  = !ctrl_r.asyncMode;
    wire logic txIdle = (txState_r == serial_pkg::TX_IDLE);
    wire logic rxIdle = (rxState_r == serial_pkg::RX_IDLE);
    wire logic [7:0] rdMux =
        (busReq.addr == serial_pkg::ADDR_BUFFER)  ? rxBuf_r :
        (busReq.addr == serial_pkg::ADDR_CONTROL) ? ctrl_r  : 8'h00;

    // ************************************************************
    // frame-mode bit clock
    // ************************************************************
    // doubling bit off passes every second overflow, halving the tick16 rate
    wire logic tick16   = timer1Ovf && (ctrl_r.baudDbl || halfTog_r);
    wire logic rxFall   = !mode0 && rxIdle && ctrl_r.rxEnable && tick16
                          && rxPrev_r && !port1Line1In;
    wire logic rollover = tick16 && !rxFall && div16_r == serial_pkg::DIV_LAST;
    // bit times line up with the counter, not with the buffer write
    wire logic asyncStep = isS1P1 && rollPend_r;
    wire logic decide   = tick16 && div16_r == serial_pkg::DECIDE;
    wire logic bitValue;

    majority_vote u_vote (
        .clock    (clock),
        .reset_n  (reset_n),
        .tick     (tick16),
        .count    (div16_r),
        .rxIn     (port1Line1In),
        .bitValue (bitValue)
    );

    // ************************************************************
    // transmit control
    // ************************************************************
    wire logic txMarker = txShift_r[8:2] == 7'h00 && txShift_r[1];
    wire logic [8:0] txShifted = {1'b0, txShift_r[8:1]};
    wire logic tx0Start = mode0 && txIdle && txPend_r && isS6P2;
    wire logic tx0Shift = txState_r == serial_pkg::TX0_SEND && isS6P2 && !txLast_r;
    wire logic tx0End   = txState_r == serial_pkg::TX0_SEND && isS1P1 && txLast_r;
    wire logic tx1End   = txState_r == serial_pkg::TX1_SEND && asyncStep
                          && txData_r && txMarker;
    wire logic txDoneSet = tx0End || tx1End;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            txState_r <= serial_pkg::TX_IDLE;
            txShift_r <= 9'h000;
            txPend_r  <= 1'b0;
            txLast_r  <= 1'b0;
            txData_r  <= 1'b0;
        end else begin
            // writes during a transfer are dropped
            if (bufWr && txIdle) begin
                txShift_r <= {1'b1, busReq.wdata};
                txPend_r  <= mode0;
                if (!mode0) txState_r <= serial_pkg::TX1_WAIT;
            end
            unique case (txState_r)
                serial_pkg::TX_IDLE: begin
                    if (tx0Start) begin
                        txPend_r  <= 1'b0;
                        txState_r <= serial_pkg::TX0_ARM;
                    end
                end
                serial_pkg::TX0_ARM: begin
                    if (isS6P2) txState_r <= serial_pkg::TX0_SEND;
                end
                serial_pkg::TX0_SEND: begin
                    if (tx0Shift) begin
                        txShift_r <= txShifted;
                        txLast_r  <= txMarker;
                    end
                    if (tx0End) begin
                        txLast_r  <= 1'b0;
                        txState_r <= serial_pkg::TX_IDLE;
                    end
                end
                serial_pkg::TX1_WAIT: begin
                    if (asyncStep) begin
                        txData_r  <= 1'b0;
                        txState_r <= serial_pkg::TX1_SEND;
                    end
                end
                serial_pkg::TX1_SEND: begin
                    if (asyncStep) begin
                        if (!txData_r) txData_r <= 1'b1;
                        else txShift_r <= txShifted;
                        if (tx1End) txState_r <= serial_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // receive control
    // ************************************************************
    wire logic rx0Ready = mode0 && rxIdle && ctrl_r.rxEnable && !ctrl_r.rxDone;
    wire logic rx0Start = rx0Ready && rxArm_r && isS6P2;
    wire logic rx0Shift = rxState_r == serial_pkg::RX0_RUN && isS6P2 && !rxLast_r;
    wire logic [7:0] rx0Next = {rxShift_r[6:0], rxSample_r};
    wire logic rx0End   = rxState_r == serial_pkg::RX0_RUN && isS1P1 && rxLast_r;
    wire logic rx1Step  = rxState_r == serial_pkg::RX1_RUN && decide;
    wire logic rx1Abort = rx1Step && rxFirst_r && bitValue;
    wire logic rx1Final = rx1Step && !rxFirst_r && !rxShift_r[0];
    wire logic rx1Ok    = !ctrl_r.rxDone && (!ctrl_r.mpCheck || bitValue);
    wire logic rxDoneSet = rx0End || (rx1Final && rx1Ok);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rxState_r <= serial_pkg::RX_IDLE;
            rxShift_r <= 9'h000;
            rxBuf_r   <= 8'h00;
            rxLast_r  <= 1'b0;
            rxFirst_r <= 1'b0;
        end else begin
            unique case (rxState_r)
                serial_pkg::RX_IDLE: begin
                    if (rx0Start) begin
                        rxShift_r <= {1'b0, serial_pkg::RX0_PRELOAD};
                        rxState_r <= serial_pkg::RX0_RUN;
                    end else if (rxFall) begin
                        rxShift_r <= serial_pkg::RX1_PRELOAD;
                        rxFirst_r <= 1'b1;
                        rxState_r <= serial_pkg::RX1_RUN;
                    end
                end
                serial_pkg::RX0_RUN: begin
                    if (rx0Shift) begin
                        rxShift_r <= {1'b0, rx0Next};
                        if (!rxShift_r[7]) begin
                            rxBuf_r  <= rx0Next;
                            rxLast_r <= 1'b1;
                        end
                    end
                    if (rx0End) begin
                        rxLast_r  <= 1'b0;
                        rxState_r <= serial_pkg::RX_IDLE;
                    end
                end
                serial_pkg::RX1_RUN: begin
                    if (rx1Step) begin
                        rxFirst_r <= 1'b0;
                        rxShift_r <= {bitValue, rxShift_r[8:1]};
                        if (rx1Final && rx1Ok) rxBuf_r <= rxShift_r[8:1];
                        if (rx1Abort || rx1Final) begin
                            rxState_r <= serial_pkg::RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // bit clock, counter and pin sampling
    // ************************************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            halfTog_r  <= 1'b0;
            div16_r    <= 4'h0;
            rollPend_r <= 1'b0;
            rxPrev_r   <= 1'b1;
            rxSample_r <= 1'b1;
            rxArm_r    <= 1'b0;
        end else begin
            if (timer1Ovf) halfTog_r <= !halfTog_r;
            if (rxFall) div16_r <= 4'h0;
            else if (tick16) div16_r <= div16_r + 4'h1;
            // a rollover in the S1P1 cycle wins over the clear
            if (rollover) rollPend_r <= 1'b1;
            else if (isS1P1 || (bufWr && txIdle)) rollPend_r <= 1'b0;
            if (tick16) rxPrev_r <= port1Line1In;
            if (isS5P2) rxSample_r <= port1Line1In;
            // armed at one S6P2, preloaded at the next one
            if (isS6P2) rxArm_r <= rx0Ready;
        end
    end

    // ************************************************************
    // control register and read port
    // ************************************************************
    serial_pkg::ctrl_t wrCtrl;
    assign wrCtrl = serial_pkg::ctrl_t'(busReq.wdata);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r   <= serial_pkg::ctrl_t'(serial_pkg::CTRL_RESET);
            rdData_r <= 8'h00;
        end else begin
            if (ctlWr) ctrl_r <= wrCtrl;
            ctrl_r.spare <= 1'b0;
            // hardware set wins over a software clear in the same cycle
            if (txDoneSet) ctrl_r.txDone <= 1'b1;
            if (rxDoneSet) ctrl_r.rxDone <= 1'b1;
            if (rx1Final && rx1Ok) ctrl_r.rxNinth <= bitValue;
            rdData_r <= busReq.rd ? rdMux : 8'h00;
        end
    end

    // ************************************************************
    // pins
    // ************************************************************
    wire logic shiftClkOn = (txState_r == serial_pkg::TX0_SEND)
                            || (rxState_r == serial_pkg::RX0_RUN);
    wire logic tx0Drive   = txState_r == serial_pkg::TX0_SEND;
    wire logic tx1Pin     = txState_r != serial_pkg::TX1_SEND ? 1'b1 :
                            txData_r ? txShift_r[0] : 1'b0;
    // in shift mode one bit per machine cycle: the rate is tied to the cpu clock
    wire logic line0Nxt   = !mode0 ? tx1Pin :
                            shiftClkOn ? clockLevel(nextPhase(phase)) : 1'b1;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            line0_r   <= 1'b1;
            line1_r   <= 1'b1;
            line1Oe_r <= 1'b0;
        end else begin
            line0_r   <= line0Nxt;
            line1_r   <= tx0Drive ? txShift_r[0] : 1'b1;
            line1Oe_r <= mode0 && tx0Drive;
        end
    end

    assign rdData        = rdData_r;
    assign port1Line0Out = line0_r;
    assign port1Line1Out = line1_r;
    assign port1Line1Oe  = line1Oe_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence armEntered;
        $rose(txState_r == serial_pkg::TX0_ARM);
    endsequence
    sequence zeroStartSeen;
        rxFirst_r && rx1Step && !bitValue;
    endsequence

    chk_tx_load_marker: assert property (
        tx0Start |=> txShift_r[8] && txState_r == serial_pkg::TX0_ARM)
        else $error("marker not loaded at transmit start");
    chk_tx_send_gap: assert property (
        armEntered |-> ##12 txState_r == serial_pkg::TX0_SEND)
        else $error("send phase not one machine cycle after arm");
    chk_shift_clock_low: assert property (
        tx0Drive && $past(tx0Drive) && mode0 && phase >= serial_pkg::PH_S3P1
        && phase < serial_pkg::PH_S6P1 |-> !port1Line0Out)
        else $error("shift clock high in states 3 to 5");
    chk_tx_shift_right: assert property (
        tx0Shift |=> txShift_r == {1'b0, $past(txShift_r[8:1])})
        else $error("transmit register did not shift right");
    chk_tx_done_set: assert property (
        tx0End |=> ctrl_r.txDone && txIdle)
        else $error("send end did not set done flag");
    chk_rx_preload: assert property (
        rx0Start |=> rxShift_r[7:0] == serial_pkg::RX0_PRELOAD)
        else $error("receive preload wrong");
    chk_rx_sample_in: assert property (
        rx0Shift |=> rxShift_r[0] == $past(rxSample_r))
        else $error("receive bit not the sampled level");
    chk_fall_reset: assert property (
        rxFall |=> div16_r == 4'h0 && rxShift_r == serial_pkg::RX1_PRELOAD)
        else $error("falling edge did not reset counter");
    chk_false_start: assert property (
        rx1Abort |=> rxIdle ##1 !ctrl_r.rxDone || $past(ctrl_r.rxDone))
        else $error("false start not rejected");
    chk_start_shift_in: assert property (
        zeroStartSeen |=> !rxShift_r[8] && rxState_r == serial_pkg::RX1_RUN)
        else $error("valid start bit not shifted in");
    chk_frame_discard: assert property (
        rx1Final && !rx1Ok |=> $stable(rxBuf_r) && rxIdle)
        else $error("refused frame changed buffer");

endmodule // serial_port

// >>> design/serial_pkg.sv
// Purpose: shared constants and types of the serial port engine
// Assumes: one clock edge per state phase, twelve phases per machine cycle
// Notes:   phase 0 is state 1 phase 1, phase 11 is state 6 phase 2
package serial_pkg;

    // ************************************************************
    // machine cycle phases
    // ************************************************************
    localparam logic [3:0] PH_LAST = 4'hB;
    localparam logic [3:0] PH_S1P1 = 4'h0;
    localparam logic [3:0] PH_S3P1 = 4'h4;
    localparam logic [3:0] PH_S5P2 = 4'h9;
    localparam logic [3:0] PH_S6P1 = 4'hA;
    localparam logic [3:0] PH_S6P2 = 4'hB;

    // ************************************************************
    // sixteenth-bit counter
    // ************************************************************
    localparam logic [3:0] DIV_LAST = 4'hF;
    localparam logic [3:0] VOTE_A   = 4'h7;
    localparam logic [3:0] VOTE_B   = 4'h8;
    localparam logic [3:0] VOTE_C   = 4'h9;
    localparam logic [3:0] DECIDE   = 4'hA;

    // ************************************************************
    // register map and preloads
    // ************************************************************
    localparam logic [1:0] ADDR_BUFFER  = 2'h0;
    localparam logic [1:0] ADDR_CONTROL = 2'h1;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] RX0_PRELOAD  = 8'hFE;
    localparam logic [8:0] RX1_PRELOAD  = 9'h1FF;

    typedef struct packed {
        logic       spare;
        logic       rxDone;    // rx_done_flag
        logic       txDone;    // tx_done_flag
        logic       rxNinth;   // rx_ninth_bit_flag
        logic       baudDbl;   // baud_doubling_bit
        logic       mpCheck;   // multiprocessor_check_bit
        logic       rxEnable;
        logic       asyncMode; // 0 shift mode, 1 ten-bit frames
    } ctrl_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } busReq_t;

    typedef enum logic [2:0] {TX_IDLE, TX0_ARM, TX0_SEND, TX1_WAIT, TX1_SEND} txState_t;
    typedef enum logic [1:0] {RX_IDLE, RX0_RUN, RX1_RUN} rxState_t;

endpackage

// >>> design/machine_phase.sv
// Purpose: state and phase counter of the machine cycle
// Assumes: twelve clock edges make one machine cycle
// Notes:   phase 0 is the first phase of the first state
module machine_phase (
    input  wire logic       clock,
    input  wire logic       reset_n,
    output logic      [3:0] phase
);
    logic [3:0] phase_r;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= serial_pkg::PH_S1P1;
        end else if (phase_r == serial_pkg::PH_LAST) begin
            phase_r <= serial_pkg::PH_S1P1;
        end else begin
            phase_r <= phase_r + 4'h1;
        end
    end

    assign phase = phase_r;
endmodule // machine_phase

// >>> design/majority_vote.sv
// Purpose: three samples per bit time, two of three decide
// Assumes: tick is the sixteen-times bit rate strobe
// Notes:   samples are kept until overwritten in the next bit time
module majority_vote (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       tick,
    input  wire logic [3:0] count,
    input  wire logic       rxIn,
    output logic            bitValue
);
    logic [2:0] samples_r;

    function automatic logic maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            samples_r <= 3'h7;
        end else if (tick) begin
            if (count == serial_pkg::VOTE_A) samples_r[0] <= rxIn;
            if (count == serial_pkg::VOTE_B) samples_r[1] <= rxIn;
            if (count == serial_pkg::VOTE_C) samples_r[2] <= rxIn;
        end
    end

    assign bitValue = maj3(samples_r);
endmodule // majority_vote

// >>> test/serial_peer.sv
// Purpose: far-side peer, external shift register or frame partner
// Assumes: line 1 has a pull-up; the bench says which mode runs
// Notes:   shift bits come from a queue, one per falling shift clock
module serial_peer (
    input  wire logic clock,
    input  wire logic frameMode,
    input  wire logic line0,
    input  wire logic line1Out,
    input  wire logic line1Oe,
    output logic      line1In
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       peerBit = 1'b1;
    logic       peerEn  = 1'b0;
    logic [7:0] txSeen  = 8'h00;
    logic       shiftQ[$];
    // released line rises to the pull-up, never keeps the last bit
    assign line1In = line1Oe ? line1Out : (peerEn ? peerBit : 1'b1);
    always @(posedge line0) begin
        if (!frameMode && line1Oe)
            txSeen <= {line1Out, txSeen[7:1]};
        else if (!frameMode && shiftQ.size() == 0)
            peerEn <= 1'b0;
    end
    always @(negedge line0) begin
        if (!frameMode && !line1Oe && shiftQ.size() != 0) begin
            peerEn  <= 1'b1;
            peerBit <= shiftQ.pop_front();
        end
    end
    task automatic send_frame(input logic [7:0] d, input logic stopBit, input int bitCyc);
        logic [9:0] fr;
        fr = {stopBit, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            peerEn  <= 1'b1;
            peerBit <= fr[i];
            repeat (bitCyc - 1) @(posedge clock);
        end
        @(posedge clock);
        peerEn <= 1'b0;
        // idle high across two ticks, else a low stop hides the next start edge
        repeat (16) @(posedge clock);
    endtask
    // mid-bit sampling tolerates the sub-cycle start lag
    task automatic get_frame(input int bitCyc, output logic [8:0] fr);
        @(negedge line0);
        repeat (bitCyc / 2) @(posedge clock);
        for (int i = 0; i < 9; i++) begin
            repeat (bitCyc) @(posedge clock);
            fr[i] = line0;
        end
    endtask
endmodule // serial_peer

// >>> test/test_serial_port.sv
// Purpose: self-checking bench of the serial port engine
// Assumes: overflow every 8 clocks, frame bit of 128 or 256 clocks
// Notes:   expectations come from a small model in plain variables
module test_serial_port;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] BUF = serial_pkg::ADDR_BUFFER;
    localparam logic [1:0] CTL = serial_pkg::ADDR_CONTROL;
    logic                clock     = 1'b0;
    logic                reset_n   = 1'b0;
    serial_pkg::busReq_t busReq    = '0;
    logic                timer1Ovf = 1'b0;
    logic                frameMode = 1'b0;
    logic          [2:0] ovfCnt    = 3'h0;
    logic         [31:0] seed      = 32'hda4b;
    logic          [7:0] rdData, v, bufM;
    logic          [8:0] f;
    logic                line1In, line1Out, line1Oe, line0Out, rxDoneM, ninthM;
    logic          [2:0] rows [4]  = '{3'b001, 3'b101, 3'b010, 3'b000};
    int                  n_fail = 0, n_checks = 0, cycles = 0;
    serial_port dut (.clock(clock), .reset_n(reset_n), .busReq(busReq), .rdData(rdData),
        .timer1Ovf(timer1Ovf), .port1Line1In(line1In), .port1Line1Out(line1Out),
        .port1Line1Oe(line1Oe), .port1Line0Out(line0Out));
    serial_peer peer (.clock(clock), .frameMode(frameMode), .line0(line0Out),
        .line1Out(line1Out), .line1Oe(line1Oe), .line1In(line1In));
    always #5 clock = ~clock;
    // ****************
    // stimulus helpers
    // ****************
    always @(posedge clock) begin
        cycles    <= cycles + 1;
        ovfCnt    <= ovfCnt + 3'h1;
        timer1Ovf <= ovfCnt == 3'h7;
        if (cycles == 40000) begin
            n_fail++;
            $display("MISMATCH %0t run did not finish", $time);
            end_sim();
        end
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] x);
        @(posedge clock);
        busReq <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
        if (a == CTL) frameMode <= x[0];
        @(posedge clock);
        busReq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] x);
        @(posedge clock);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        busReq.rd <= 1'b0;
        #1 x = rdData;
    endtask
    // bounded poll; a flag that never comes fails the next compare
    task automatic wait_flag(input int bitNo);
        for (int i = 0; i < 3000; i++) begin
            rd(CTL, v);
            if (v[bitNo] === 1'b1) break;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        rd(CTL, v);
        check(v, serial_pkg::CTRL_RESET);
        rd(2'h2, v);
        check(v, 8'h00);
        seed = xorshift(seed);
        wr(BUF, seed[7:0]);
        wait_flag(5);
        check(v, 8'h20);
        check(peer.txSeen, seed[7:0]);
        for (int i = 8; i < 16; i++) peer.shiftQ.push_back(seed[i]);
        bufM = {<<{seed[15:8]}};
        wr(CTL, 8'h02);
        wait_flag(6);
        check(v, 8'h42);
        rd(BUF, v);
        check(v, bufM);
        for (int dbl = 1; dbl >= 0; dbl--) begin
            wr(CTL, 8'h01 | 8'(dbl << 3));
            seed = xorshift(seed);
            wr(BUF, seed[7:0]);
            peer.get_frame(dbl ? 128 : 256, f);
            check(f, {1'b1, seed[7:0]});
            wait_flag(5);
            check(v, 8'h21 | 8'(dbl << 3));
        end
        wr(CTL, 8'h0B);
        peer.send_frame(8'hFF, 1'b1, 24);
        rd(CTL, v);
        check(v, 8'h0B);
        for (int r = 0; r < 4; r++) begin
            if (!rows[r][2]) begin
                wr(CTL, 8'h0B | 8'(rows[r][1] << 2));
                rxDoneM = 1'b0;
                ninthM  = 1'b0;
            end
            seed = xorshift(seed);
            if (!rxDoneM && (!rows[r][1] || rows[r][0])) begin
                rxDoneM = 1'b1;
                ninthM  = rows[r][0];
                bufM    = seed[7:0];
            end
            peer.send_frame(seed[7:0], rows[r][0], 128);
            rd(CTL, v);
            check(v, {1'b0, rxDoneM, 1'b0, ninthM, 1'b1, rows[r][1], 2'b11});
            rd(BUF, v);
            check(v, bufM);
        end
        end_sim();
    end
endmodule // test_serial_port
